// ===== hdl/modbus_cfg.svh
// constants shared by both ends of the serial command link
`ifndef MODBUS_CFG_SVH
`define MODBUS_CFG_SVH
`define MB_FN_DIAG 8'h08
`define MB_FN_WRMULTI 8'h10
`define MB_SUB_ECHO 16'h0000
`define MB_MAX_REGS 123
`define MB_EXC_FLAG 8'h80
`define MB_EXC_CODE 8'h03
`define MB_CRC_INIT 16'hffff
`define MB_CRC_POLY 16'ha001
`define MB_DIAG_LEN 9'd8
`define MB_WR_OVERHEAD 9'd9
`define MB_WR_DATA_POS 9'd7
`define MB_ACK_HDR_LEN 3'd6
`define MB_EXC_HDR_LEN 3'd3
`define MB_BUF_BYTES 256
`define MB_REPLY_WAIT_CYC 1024
`endif

// ===== hdl/modbus_pkg.sv
// types and the check-sum step shared by both ends
`include "modbus_cfg.svh"
package modbus_pkg;
   typedef logic [15:0] crc16_t;
   typedef logic [7:0] byte_t;

   // one byte of the reflected 16-bit check sum, low bit first
   function automatic crc16_t crc16_step(input crc16_t crcIn, input byte_t dataIn);
      crc16_t c;
      c = crcIn ^ {8'h00, dataIn};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `MB_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

// ===== hdl/modbus_link_if.sv
// byte stream link between the command master and the responding slave
interface modbus_link_if;
   logic qValid;
   logic [7:0] qData;
   logic qLast;
   logic rValid;
   logic [7:0] rData;
   logic rLast;
   modport slave_end (input qValid, input qData, input qLast, output rValid, output rData, output rLast);
   modport master_end (output qValid, output qData, output qLast, input rValid, input rData, input rLast);
endinterface

// ===== hdl/modbus_slave_end.sv
// slave end: diagnosis echo and multiple holding register write
`include "modbus_cfg.svh"

module modbus_slave_end import modbus_pkg::*; #(
   parameter int MaxRegs = `MB_MAX_REGS
) (
   input wire logic clock,
   input wire logic nrst,
   modbus_link_if.slave_end link,
   input wire logic [7:0] slaveAddr,
   output logic regWrValid,
   output logic [15:0] regWrAddr,
   output logic [15:0] regWrData,
   input wire logic regWrReject,
   output logic frameDropped
);
   typedef enum logic [2:0] {
      S_RX = 3'b000,
      S_CHECK = 3'b001,
      S_WRITE = 3'b010,
      S_DRAIN = 3'b011,
      S_SEND = 3'b100
   } slave_state_t;

   slave_state_t state_q;
   byte_t mem [0:`MB_BUF_BYTES-1];
   logic [8:0] rxIdx_q;
   logic rxOvf_q;
   crc16_t rxCrc_q;
   logic [6:0] wrIdx_q;
   logic excFlag_q;
   logic [2:0] hdrLen_q;
   logic [2:0] txIdx_q;
   crc16_t txCrc_q;
   logic [15:0] startAddr;
   logic [15:0] regCount;
   logic [15:0] subFn;
   logic diagOk;
   logic wrOk;
   logic [8:0] wrPos;
   byte_t hdrByte;
   logic frameGood;

   // ---------------------------------------------------------------
   // query field decode
   // ---------------------------------------------------------------
   assign subFn = {mem[2], mem[3]};
   assign startAddr = {mem[2], mem[3]};
   assign regCount = {mem[4], mem[5]};
   assign diagOk = (mem[1] == `MB_FN_DIAG) && (subFn == `MB_SUB_ECHO)
      && (rxIdx_q == `MB_DIAG_LEN);
   assign wrOk = (mem[1] == `MB_FN_WRMULTI) && (regCount != 16'h0000)
      && (regCount <= 16'(MaxRegs))
      && (mem[6] == {regCount[6:0], 1'b0})
      && (rxIdx_q == `MB_WR_OVERHEAD + {1'b0, regCount[6:0], 1'b0});
   assign frameGood = (rxCrc_q == 16'h0000) && !rxOvf_q;
   assign wrPos = `MB_WR_DATA_POS + {1'b0, wrIdx_q, 1'b0};

   // ---------------------------------------------------------------
   // frame buffer, no reset so it maps to memory
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (state_q == S_RX && link.qValid && !rxIdx_q[8]) begin
         mem[rxIdx_q[7:0]] <= link.qData;
      end
   end

   // ---------------------------------------------------------------
   // receive counter and running check sum
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rxIdx_q <= 9'd0;
         rxOvf_q <= 1'b0;
         rxCrc_q <= `MB_CRC_INIT;
      end else if (state_q == S_RX && link.qValid) begin
         rxCrc_q <= crc16_step(rxCrc_q, link.qData);
         if (rxIdx_q[8]) begin
            rxOvf_q <= 1'b1;
         end else begin
            rxIdx_q <= rxIdx_q + 9'd1;
         end
      end else if (state_q == S_SEND && txIdx_q == hdrLen_q + 3'd1) begin
         rxIdx_q <= 9'd0;
         rxOvf_q <= 1'b0;
         rxCrc_q <= `MB_CRC_INIT;
      end else if (state_q == S_CHECK && !(frameGood && mem[0] == slaveAddr && (diagOk || wrOk))) begin
         rxIdx_q <= 9'd0;
         rxOvf_q <= 1'b0;
         rxCrc_q <= `MB_CRC_INIT;
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_RX;
         wrIdx_q <= 7'd0;
         hdrLen_q <= `MB_ACK_HDR_LEN;
         frameDropped <= 1'b0;
      end else begin
         frameDropped <= 1'b0;
         case (state_q)
            S_RX: begin
               if (link.qValid && link.qLast) begin
                  state_q <= S_CHECK;
               end
            end
            S_CHECK: begin
               wrIdx_q <= 7'd0;
               hdrLen_q <= `MB_ACK_HDR_LEN;
               if (!frameGood) begin
                  frameDropped <= 1'b1;
                  state_q <= S_RX;
               end else if (mem[0] != slaveAddr || !(diagOk || wrOk)) begin
                  state_q <= S_RX;
               end else if (wrOk) begin
                  state_q <= S_WRITE;
               end else begin
                  state_q <= S_SEND;
               end
            end
            S_WRITE: begin
               wrIdx_q <= wrIdx_q + 7'd1;
               if (wrIdx_q == regCount[6:0] - 7'd1) begin
                  state_q <= S_DRAIN;
               end
            end
            S_DRAIN: begin
               hdrLen_q <= (excFlag_q || regWrReject) ? `MB_EXC_HDR_LEN : `MB_ACK_HDR_LEN;
               state_q <= S_SEND;
            end
            S_SEND: begin
               if (txIdx_q == hdrLen_q + 3'd1) begin
                  state_q <= S_RX;
               end
            end
            default: begin
               state_q <= S_RX;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // holding register write strobe, one word per cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         regWrValid <= 1'b0;
         regWrAddr <= 16'h0000;
         regWrData <= 16'h0000;
      end else begin
         regWrValid <= (state_q == S_WRITE);
         if (state_q == S_WRITE) begin
            regWrAddr <= startAddr + {9'd0, wrIdx_q};
            regWrData <= {mem[wrPos[7:0]], mem[wrPos[7:0] + 8'd1]};
         end
      end
   end

   // rejects collected while words keep being stored
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         excFlag_q <= 1'b0;
      end else if (state_q == S_CHECK) begin
         excFlag_q <= 1'b0;
      end else if (regWrValid && regWrReject) begin
         excFlag_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // reply header: echo of query head, or exception form
   // ---------------------------------------------------------------
   always_comb begin
      hdrByte = mem[txIdx_q];
      if (hdrLen_q == `MB_EXC_HDR_LEN) begin
         if (txIdx_q == 3'd1) begin
            hdrByte = mem[1] | `MB_EXC_FLAG;
         end else if (txIdx_q == 3'd2) begin
            hdrByte = `MB_EXC_CODE;
         end
      end
   end

   // ---------------------------------------------------------------
   // transmit with freshly computed check sum
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txIdx_q <= 3'd0;
         txCrc_q <= `MB_CRC_INIT;
         link.rValid <= 1'b0;
         link.rData <= 8'h00;
         link.rLast <= 1'b0;
      end else begin
         link.rValid <= 1'b0;
         link.rLast <= 1'b0;
         if (state_q == S_SEND) begin
            link.rValid <= 1'b1;
            txIdx_q <= txIdx_q + 3'd1;
            if (txIdx_q < hdrLen_q) begin
               link.rData <= hdrByte;
               txCrc_q <= crc16_step(txCrc_q, hdrByte);
            end else if (txIdx_q == hdrLen_q) begin
               link.rData <= txCrc_q[7:0];
            end else begin
               link.rData <= txCrc_q[15:8];
               link.rLast <= 1'b1;
               txIdx_q <= 3'd0;
               txCrc_q <= `MB_CRC_INIT;
            end
         end
      end
   end
endmodule

// ===== hdl/modbus_master_end.sv
// master end: issues diagnosis and multiple write queries, checks replies
`include "modbus_cfg.svh"

module modbus_master_end import modbus_pkg::*; #(
   parameter int ReplyWaitCyc = `MB_REPLY_WAIT_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   modbus_link_if.master_end link,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdDiag,
   input wire logic [7:0] cmdSlave,
   input wire logic [15:0] cmdWordA,
   input wire logic [6:0] cmdCount,
   output logic wordTake,
   output logic [6:0] wordIdx,
   input wire logic [15:0] wordIn,
   output logic doneValid,
   output logic doneOk,
   output logic doneExc,
   output logic doneTimeout
);
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_SEND = 2'b01,
      M_WAIT = 2'b10,
      M_CHECK = 2'b11
   } master_state_t;

   master_state_t state_q;
   logic diag_q;
   byte_t slave_q;
   logic [15:0] wordA_q;
   logic [6:0] count_q;
   logic [8:0] sIdx_q;
   logic [8:0] sLen;
   logic [8:0] dOff;
   byte_t lowByte_q;
   crc16_t sCrc_q;
   byte_t txByte;
   byte_t rBuf [0:7];
   logic [3:0] rCnt_q;
   crc16_t rCrc_q;
   logic [31:0] wait_q;
   logic matchOk;

   assign cmdReady = (state_q == M_IDLE);
   assign sLen = diag_q ? `MB_DIAG_LEN : `MB_WR_OVERHEAD + {1'b0, count_q, 1'b0};
   assign dOff = sIdx_q - `MB_WR_DATA_POS;
   assign wordIdx = dOff[7:1];
   assign wordTake = (state_q == M_SEND) && !diag_q && (sIdx_q >= `MB_WR_DATA_POS)
      && (sIdx_q < sLen - 9'd2) && !dOff[0];

   // ---------------------------------------------------------------
   // query byte selection by position
   // ---------------------------------------------------------------
   always_comb begin
      txByte = 8'h00;
      if (sIdx_q == sLen - 9'd2) begin
         txByte = sCrc_q[7:0];
      end else if (sIdx_q == sLen - 9'd1) begin
         txByte = sCrc_q[15:8];
      end else if (sIdx_q == 9'd0) begin
         txByte = slave_q;
      end else if (sIdx_q == 9'd1) begin
         txByte = diag_q ? `MB_FN_DIAG : `MB_FN_WRMULTI;
      end else if (sIdx_q == 9'd2) begin
         txByte = diag_q ? 8'(`MB_SUB_ECHO >> 8) : wordA_q[15:8];
      end else if (sIdx_q == 9'd3) begin
         txByte = diag_q ? 8'(`MB_SUB_ECHO) : wordA_q[7:0];
      end else if (sIdx_q == 9'd4) begin
         txByte = diag_q ? wordA_q[15:8] : 8'h00;
      end else if (sIdx_q == 9'd5) begin
         txByte = diag_q ? wordA_q[7:0] : {1'b0, count_q};
      end else if (sIdx_q == 9'd6) begin
         txByte = {count_q, 1'b0};
      end else if (!dOff[0]) begin
         txByte = wordIn[15:8];
      end else begin
         txByte = lowByte_q;
      end
   end

   // ---------------------------------------------------------------
   // command capture and query transmit
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= M_IDLE;
         diag_q <= 1'b0;
         slave_q <= 8'h00;
         wordA_q <= 16'h0000;
         count_q <= 7'd0;
         sIdx_q <= 9'd0;
         sCrc_q <= `MB_CRC_INIT;
         lowByte_q <= 8'h00;
         wait_q <= 32'd0;
         link.qValid <= 1'b0;
         link.qData <= 8'h00;
         link.qLast <= 1'b0;
      end else begin
         link.qValid <= 1'b0;
         link.qLast <= 1'b0;
         case (state_q)
            M_IDLE: begin
               if (cmdValid) begin
                  diag_q <= cmdDiag;
                  slave_q <= cmdSlave;
                  wordA_q <= cmdWordA;
                  count_q <= (cmdCount > 7'(`MB_MAX_REGS)) ? 7'(`MB_MAX_REGS) : cmdCount;
                  sIdx_q <= 9'd0;
                  sCrc_q <= `MB_CRC_INIT;
                  state_q <= M_SEND;
               end
            end
            M_SEND: begin
               link.qValid <= 1'b1;
               link.qData <= txByte;
               sIdx_q <= sIdx_q + 9'd1;
               if (sIdx_q < sLen - 9'd2) begin
                  sCrc_q <= crc16_step(sCrc_q, txByte);
               end
               if (wordTake) begin
                  lowByte_q <= wordIn[7:0];
               end
               if (sIdx_q == sLen - 9'd1) begin
                  link.qLast <= 1'b1;
                  wait_q <= 32'd0;
                  state_q <= M_WAIT;
               end
            end
            M_WAIT: begin
               wait_q <= wait_q + 32'd1;
               if (link.rValid && link.rLast) begin
                  state_q <= M_CHECK;
               end else if (wait_q == 32'(ReplyWaitCyc - 1)) begin
                  state_q <= M_IDLE;
               end
            end
            default: begin
               state_q <= M_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // reply capture, first eight bytes kept
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (state_q == M_WAIT && link.rValid && !rCnt_q[3]) begin
         rBuf[rCnt_q[2:0]] <= link.rData;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rCnt_q <= 4'd0;
         rCrc_q <= `MB_CRC_INIT;
      end else if (state_q == M_SEND) begin
         rCnt_q <= 4'd0;
         rCrc_q <= `MB_CRC_INIT;
      end else if (state_q == M_WAIT && link.rValid) begin
         rCrc_q <= crc16_step(rCrc_q, link.rData);
         if (rCnt_q != 4'hf) begin
            rCnt_q <= rCnt_q + 4'd1;
         end
      end
   end

   // reply must repeat the query head; diagnosis also the test value
   assign matchOk = (rCnt_q == 4'd8) && (rBuf[0] == slave_q) && (rBuf[1] == (diag_q ? `MB_FN_DIAG : `MB_FN_WRMULTI))
      && ({rBuf[2], rBuf[3]} == (diag_q ? `MB_SUB_ECHO : wordA_q))
      && ({rBuf[4], rBuf[5]} == (diag_q ? wordA_q : {9'd0, count_q}));

   // ---------------------------------------------------------------
   // completion report
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         doneValid <= 1'b0;
         doneOk <= 1'b0;
         doneExc <= 1'b0;
         doneTimeout <= 1'b0;
      end else begin
         doneValid <= 1'b0;
         if (state_q == M_CHECK) begin
            doneValid <= 1'b1;
            doneTimeout <= 1'b0;
            doneOk <= (rCrc_q == 16'h0000) && matchOk;
            doneExc <= (rCrc_q == 16'h0000) && (rCnt_q == 4'd5) && rBuf[1][7];
         end else if (state_q == M_WAIT && !(link.rValid && link.rLast) && wait_q == 32'(ReplyWaitCyc - 1)) begin
            doneValid <= 1'b1;
            doneTimeout <= 1'b1;
            doneOk <= 1'b0;
            doneExc <= 1'b0;
         end
      end
   end
endmodule

// ===== tb/modbus_diag_multiwrite_handler_assertions.sv
// checker of the query and reply byte streams on the link
module modbus_diag_multiwrite_handler_assertions (
   input wire logic clock,
   input wire logic nrst,
   input wire logic qValid,
   input wire logic [7:0] qData,
   input wire logic qLast,
   input wire logic rValid,
   input wire logic [7:0] rData,
   input wire logic rLast
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] qIdx_q;
   logic [3:0] rIdx_q;
   logic [7:0] qBuf_q [8];
   logic [7:0] rFn_q;
   logic [15:0] qCrc_q;
   logic [15:0] rCrc_q;

   // one byte of the reflected check sum
   function automatic logic [15:0] step(logic [15:0] c, logic [7:0] d);
      c = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   // byte positions, first query bytes and running check sums
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         qIdx_q <= 4'h0;
         rIdx_q <= 4'h0;
         qCrc_q <= 16'hffff;
         rCrc_q <= 16'hffff;
         rFn_q <= 8'h00;
      end else begin
         if (qValid) begin
            qIdx_q <= qLast ? 4'h0 : qIdx_q + {3'h0, qIdx_q != 4'h8};
            qCrc_q <= qLast ? 16'hffff : step(qCrc_q, qData);
            if (qIdx_q < 4'h8) qBuf_q[qIdx_q[2:0]] <= qData;
         end
         if (rValid) begin
            rIdx_q <= rLast ? 4'h0 : rIdx_q + {3'h0, rIdx_q != 4'h8};
            rCrc_q <= rLast ? 16'hffff : step(rCrc_q, rData);
            if (rIdx_q == 4'h1) rFn_q <= rData;
         end
      end
   end

   qlast_has_valid_a: assert property (qLast |-> qValid) else $error("query end without byte");
   rlast_has_valid_a: assert property (rLast |-> rValid) else $error("reply end without byte");
   query_no_gap_a: assert property (qValid && !qLast |=> qValid) else $error("gap inside query");
   reply_after_query_a: assert property (rValid |-> !qValid) else $error("reply overlaps query");
   query_check_sum_a: assert property (qValid && qLast |-> step(qCrc_q, qData) == 16'h0000)
      else $error("query check sum residue not zero");
   reply_check_sum_a: assert property (rValid && rLast |-> step(rCrc_q, rData) == 16'h0000)
      else $error("reply check sum residue not zero");
   reply_station_a: assert property (rValid && rIdx_q == 4'h0 |-> rData == qBuf_q[0])
      else $error("reply station differs");
   reply_function_a: assert property (rValid && rIdx_q == 4'h1 |-> rData == qBuf_q[1] || rData == (qBuf_q[1] | 8'h80))
      else $error("reply function differs");
   diag_echo_bytes_a: assert property (rValid && qBuf_q[1] == 8'h08 |-> rIdx_q < 4'h8 && rData == qBuf_q[rIdx_q[2:0]])
      else $error("diagnosis reply byte differs");
   diag_reply_start_a: assert property ($rose(rValid) && qBuf_q[1] == 8'h08 |-> $past(qLast, 3))
      else $error("diagnosis reply late or early");
   diag_reply_len_a: assert property (rLast && qBuf_q[1] == 8'h08 |-> rIdx_q == 4'h7)
      else $error("diagnosis reply length");
   write_ack_echo_a: assert property (rValid && qBuf_q[1] == 8'h10 && rFn_q == 8'h10 && rIdx_q >= 4'h2 && rIdx_q <= 4'h5
      |-> rData == qBuf_q[rIdx_q[2:0]]) else $error("write reply start or count differs");
   write_reply_len_a: assert property (rLast && qBuf_q[1] == 8'h10 |-> (rFn_q == 8'h10 && rIdx_q == 4'h7)
      || (rFn_q == 8'h90 && rIdx_q == 4'h4)) else $error("write reply length");
endmodule

// ===== tb/modbus_diag_multiwrite_handler_tb_top.sv
// bench joining both ends, plus a slave end fed with one good frame and several faulty frames
module modbus_diag_multiwrite_handler_tb_top import modbus_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   typedef byte_t frame_t[$];
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic cmdValid = 1'b0;
   logic cmdDiag = 1'b0;
   logic [7:0] cmdSlave = 8'h00;
   logic [15:0] cmdWordA = 16'h0000;
   logic [6:0] cmdCount = 7'h00;
   logic [7:0] addrA = 8'h03;
   logic [7:0] addrB = 8'h05;
   logic rejOn = 1'b0;
   logic [15:0] rejAddr = 16'h0000;
   logic [15:0] words [128];
   logic [15:0] v;
   logic [15:0] s;
   wire logic cmdReady, wordTake, doneValid, doneOk, doneExc, doneTimeout;
   wire logic [6:0] wordIdx;
   wire logic regWrValid, regWrReject, frameDropped, dropPulseB;
   wire logic [15:0] regWrAddr, regWrData;
   int err_count = 0;
   int cmp_count = 0;
   int seed = 32'h11af;
   int n;
   int rCntB;
   int dropB;
   int dropA = 0;
   int takes;
   frame_t qSeen, rSeen, exp;
   logic [15:0] wrAddr[$];
   logic [15:0] wrData[$];
   modbus_link_if linkA();
   modbus_link_if linkB();

   // word source and reject of writes to one chosen address
   assign regWrReject = rejOn && regWrValid && regWrAddr === rejAddr;

   modbus_master_end #(.ReplyWaitCyc(256)) i_modbus_master_end (.clock(clock), .nrst(nrst), .link(linkA),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdDiag(cmdDiag), .cmdSlave(cmdSlave), .cmdWordA(cmdWordA),
      .cmdCount(cmdCount), .wordTake(wordTake), .wordIdx(wordIdx), .wordIn(words[wordIdx]),
      .doneValid(doneValid), .doneOk(doneOk), .doneExc(doneExc), .doneTimeout(doneTimeout));
   modbus_slave_end i_modbus_slave_end (.clock(clock), .nrst(nrst), .link(linkA), .slaveAddr(addrA),
      .regWrValid(regWrValid), .regWrAddr(regWrAddr), .regWrData(regWrData), .regWrReject(regWrReject),
      .frameDropped(frameDropped));
   modbus_slave_end i_modbus_slave_end_b (.clock(clock), .nrst(nrst), .link(linkB), .slaveAddr(addrB),
      .regWrValid(), .regWrAddr(), .regWrData(), .regWrReject(1'b0), .frameDropped(dropPulseB));
   modbus_diag_multiwrite_handler_assertions i_modbus_diag_multiwrite_handler_assertions (.clock(clock),
      .nrst(nrst), .qValid(linkA.qValid), .qData(linkA.qData), .qLast(linkA.qLast), .rValid(linkA.rValid),
      .rData(linkA.rData), .rLast(linkA.rLast));

   // clock of 100 ns period
   initial forever #50 clock = ~clock;

   // records link bytes and stored words
   always @(negedge clock) begin
      if (linkA.qValid) qSeen.push_back(linkA.qData);
      if (linkA.rValid) rSeen.push_back(linkA.rData);
      if (regWrValid) begin
         wrAddr.push_back(regWrAddr);
         wrData.push_back(regWrData);
      end
      if (linkB.rValid) rCntB++;
      if (dropPulseB) dropB++;
      if (frameDropped) dropA++;
      if (wordTake) takes++;
   end

   // appends the check sum, low byte first
   function automatic frame_t addCrc(frame_t f);
      crc16_t c = 16'hffff;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      return f;
   endfunction

   // multiple write query from the word table
   function automatic frame_t wrFrame(byte_t a, logic [15:0] st, int cnt, byte_t bc);
      frame_t f = {a, 8'h10, st[15:8], st[7:0], 8'h00, byte_t'(cnt), bc};
      for (int k = 0; k < cnt; k++) begin
         f.push_back(words[k][15:8]);
         f.push_back(words[k][7:0]);
      end
      return addCrc(f);
   endfunction

   task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic cmpFrame(string name, frame_t seen, frame_t expv);
      check({name, " length"}, seen.size(), expv.size());
      foreach (expv[i]) if (i < seen.size()) check(name, seen[i], expv[i]);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // one command through the master end, bounded wait for done
   task automatic runA(logic diag, byte_t sl, logic [15:0] wa, logic [6:0] cnt);
      int i;
      qSeen.delete();
      rSeen.delete();
      wrAddr.delete();
      wrData.delete();
      takes = 0;
      @(negedge clock);
      check("ready", cmdReady, 1'b1);
      cmdValid = 1'b1;
      cmdDiag = diag;
      cmdSlave = sl;
      cmdWordA = wa;
      cmdCount = cnt;
      @(negedge clock);
      cmdValid = 1'b0;
      for (i = 0; i < 4000; i++) begin
         @(negedge clock);
         if (doneValid === 1'b1) break;
      end
      if (i == 4000) begin
         err_count++;
         test_done();
      end
      @(negedge clock);
   endtask

   // raw frame into the second slave end, then watch for a reply
   task automatic sendB(frame_t f);
      rCntB = 0;
      dropB = 0;
      foreach (f[i]) begin
         @(negedge clock);
         linkB.qValid = 1'b1;
         linkB.qData = f[i];
         linkB.qLast = (i == f.size() - 1);
      end
      @(negedge clock);
      linkB.qValid = 1'b0;
      linkB.qLast = 1'b0;
      linkB.qData = ~linkB.qData;
      repeat (300) @(negedge clock);
   endtask

   // main sequence
   initial begin
      linkB.qValid = 1'b0;
      linkB.qData = 8'h00;
      linkB.qLast = 1'b0;
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      for (int t = 0; t < 6; t++) begin
         v = (t == 0) ? 16'h1234 : 16'($random(seed));
         runA(1'b1, addrA, v, 7'h00);
         exp = addCrc({addrA, 8'h08, 8'h00, 8'h00, v[15:8], v[7:0]});
         if (t == 0) check("sample sum", {exp[6], exp[7]}, 16'hec9e);
         cmpFrame("diag query", qSeen, exp);
         cmpFrame("diag reply", rSeen, exp);
         check("diag done", {doneOk, doneExc, doneTimeout}, 3'b100);
      end
      for (int t = 0; t < 6; t++) begin
         n = (t == 0) ? 1 : (t == 1) ? 123 : 1 + ({$random(seed)} % 123);
         s = 16'($random(seed));
         foreach (words[k]) words[k] = 16'($random(seed));
         rejOn = (t == 5);
         rejAddr = s + 16'(n / 2);
         runA(1'b0, addrA, s, 7'(n));
         cmpFrame("write query", qSeen, wrFrame(addrA, s, n, byte_t'(2 * n)));
         check("word count", wrAddr.size(), n);
         check("word takes", takes, n);
         foreach (wrAddr[k]) begin
            check("word addr", wrAddr[k], 16'(s + 16'(k)));
            check("word data", wrData[k], words[k]);
         end
         if (rejOn) exp = addCrc({addrA, 8'h90, 8'h03});
         else exp = addCrc({addrA, 8'h10, s[15:8], s[7:0], 8'h00, byte_t'(n)});
         cmpFrame("write reply", rSeen, exp);
         check("write done", {doneOk, doneExc}, rejOn ? 2'b01 : 2'b10);
      end
      rejOn = 1'b0;
      runA(1'b1, addrA + 8'h01, 16'h5a5a, 7'h00);
      check("foreign reply", rSeen.size(), 0);
      check("foreign timeout", doneTimeout, 1'b1);
      exp = addCrc({addrB, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
      sendB(exp);
      check("good reply", rCntB, 8);
      exp[6] = exp[6] ^ 8'h01;
      sendB(exp);
      check("bad sum reply", rCntB, 0);
      check("bad sum drop", dropB, 1);
      sendB(addCrc({addrB, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00}));
      check("sub-function reply", rCntB, 0);
      sendB(wrFrame(addrB, 16'h0100, 124, 8'hf8));
      check("over count reply", rCntB, 0);
      sendB(wrFrame(addrB, 16'h0100, 2, 8'h05));
      check("byte count reply", rCntB, 0);
      check("clean link drops", dropA, 0);
      test_done();
   end
endmodule
